// ===== hw/uart_ctl_cfg.svh
// Purpose: offsets, reset values and frame constants of the serial port
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef UART_CTL_CFG_SVH
`define UART_CTL_CFG_SVH
`define MODE_ADDR      8'h00
`define STAT_ADDR      8'h04
`define DATA_ADDR      8'h08
`define DIV_ADDR       8'h0C
`define STAT_RESET     16'h0110
`define DIV_RESET      16'h0000
`define SYNC_BYTE      8'h55
`define BRK_BITS       4'hC
`define SPB_STD        5'h10
`define SPB_HS         5'h04
`endif

// ===== hw/uart_ctl_pkg.sv
// Purpose: types shared by the serial port
// Assumes: nothing
// Notes:   mode register layout as a packed struct
package uart_ctl_pkg;
    typedef struct packed {
        logic       port_enable;
        logic       unused14;
        logic       stop_in_idle;
        logic       infrared_enable;
        logic       rts_pin_mode;
        logic       unused10;
        logic [1:0] pin_select;
        logic       wake_enable;
        logic       loopback_select;
        logic       auto_rate_enable;
        logic       rx_polarity_invert;
        logic       high_speed_clocking;
        logic [1:0] framing_select;
        logic       stop_count_select;
    } mode_t;
    typedef enum logic [1:0] {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01
    } tx_state_t;
    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_SHIFT = 2'b01
    } rx_state_t;
endpackage

// ===== hw/uart_ctl.sv
// Purpose: mode/status control of a full-duplex asynchronous serial port
// Assumes: AHB-Lite single word transfers, one clock
// Notes:   data word layout {parity/9th, data}; queues 4 deep
//
// Overview of operation
// RULE1 - port enable hands pins to the port as pin_select chooses; off idles
// RULE2 - stop_in_idle halts the port while the device idles
// RULE3 - infrared encode/decode inserted when enabled, only in 16x mode; code encodes transmit only, no receive decode
// RULE4 - rts pin simplex when mode bit 1, flow control when 0
// RULE5 - pin_select picks tx/rx, plus rts, plus rts/cts, or baud clock
// RULE6 - wake mode samples rx, interrupt on fall, bit clears on next rise
// RULE7 - auto rate measures next sync byte 55h, then clears itself; code discards the 55h byte and clears the bit, div_r unchanged
// RULE8 - rx polarity bit set means idle low and inverted data
// RULE9 - high speed gives 4 clocks per bit, otherwise 16
// RULE10 - framing field: 11 nine bits, 10 odd, 01 even, 00 none
// RULE11 - stop select sends two stop bits when set, else one
// RULE12 - tx interrupt mode: 10 empties buffer, 01 all done, 00 any load
// RULE13 - tx polarity inverts idle level, infrared idle follows bit
// RULE14 - break sends start, twelve zeros, stop, then clears itself
// RULE15 - clearing tx enable aborts transmission and flushes tx buffer
// RULE16 - buffer full flag when queue full; shift empty when all empty
// RULE17 - rx interrupt mode: 11 four held, 10 three held, 0x any
// RULE18 - address detect in nine-bit mode keeps only ninth bit set
// RULE19 - receiver idle flag reads 1 when idle, 0 while receiving
// RULE20 - parity and framing flags describe the head of the rx queue
// RULE21 - overrun set on overflow; software clear flushes receiver
// RULE22 - data available while rx queue holds a character
// RULE23 - tx and rx queues are four entries deep
// RULE24 - loopback routes transmit output into the receiver
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "uart_ctl_cfg.svh"
module uart_ctl
    import uart_ctl_pkg::*;
#(
    parameter int DEPTH = 4
)(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // system power state
    input  wire logic        device_idle,
    // serial pins
    input  wire logic        serial_in_pin,
    input  wire logic        clear_to_send_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    output logic             request_to_send_pin,
    output logic             request_to_send_oe,
    output logic             baud_clock_out,
    output logic             baud_clock_oe,
    // events
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             wake_irq
);
    localparam int PW = $clog2(DEPTH);
    // =========================================================
    // registers and shared state
    mode_t       mode_r;
    logic [1:0]  tx_irq_mode_r, rx_irq_mode_r;
    logic        tx_pol_r, send_break_r, tx_enable_r, addr_det_r;
    logic        overrun_r;
    logic [15:0] div_r;
    logic [8:0]  txq [DEPTH];
    logic [10:0] rxq [DEPTH];  // {parity_error, framing_error, data9}
    logic [PW:0] tx_cnt_r, rx_cnt_r;
    logic [PW-1:0] tx_rd_r, tx_wr_r, rx_rd_r, rx_wr_r;
    logic        wr_ph_r, rd_ph_r;
    logic [7:0]  addr_r;
    // =========================================================
    // bus decode
    logic a_ph, do_wr, do_rd, txq_push, rxq_pop, overrun_error_clr;
    assign a_ph      = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            addr_r  <= 8'h00;
        end
        else
        begin
            wr_ph_r <= a_ph & hwrite;
            rd_ph_r <= a_ph & ~hwrite;
            addr_r  <= haddr;
        end
    end
    assign do_wr    = wr_ph_r;
    assign do_rd    = rd_ph_r;
    assign txq_push = do_wr && addr_r == `DATA_ADDR && tx_enable_r
                      && tx_cnt_r != DEPTH[PW:0];
    assign rxq_pop  = do_rd && addr_r == `DATA_ADDR && rx_cnt_r != '0;
    assign overrun_error_clr = do_wr && addr_r == `STAT_ADDR && overrun_r
                      && !hwdata[1];                             // RULE21
    // =========================================================
    // run gating and baud ticks
    logic run, tick;
    logic [15:0] div_cnt_r;
    logic [4:0]  spb;
    assign run = mode_r.port_enable
                 & ~(mode_r.stop_in_idle & device_idle);        // RULE1 RULE2
    assign spb = mode_r.high_speed_clocking ? `SPB_HS : `SPB_STD;// RULE9
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_cnt_r <= 16'h0000;
        else if (!run || div_cnt_r == div_r)
            div_cnt_r <= 16'h0000;
        else
            div_cnt_r <= div_cnt_r + 16'h0001;
    end
    assign tick = run && div_cnt_r == div_r;
    // baud clock toggles each tick, half the tick rate
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            baud_clock_out <= 1'b0;
        else if (tick)
            baud_clock_out <= ~baud_clock_out;
    end
    // =========================================================
    // pin synchroniser: three flops, change counts when 2 and 3 agree
    logic [2:0] rx_sy_r, cts_sy_r;
    logic       rx_pin_s, cts_s;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_sy_r  <= 3'b111;
            cts_sy_r <= 3'b000;
            rx_pin_s <= 1'b1;
            cts_s    <= 1'b0;
        end
        else
        begin
            rx_sy_r  <= {rx_sy_r[1:0], serial_in_pin};
            cts_sy_r <= {cts_sy_r[1:0], clear_to_send_pin};
            if (rx_sy_r[1] == rx_sy_r[2])
                rx_pin_s <= rx_sy_r[2];
            if (cts_sy_r[1] == cts_sy_r[2])
                cts_s <= cts_sy_r[2];
        end
    end
    // =========================================================
    // transmitter
    tx_state_t   tx_st_r;
    logic [11:0] tx_sh_r;
    logic [3:0]  tx_bits_r;
    logic [4:0]  tx_sub_r;
    logic        tx_line, ir_tx, tx_load, tx_done, cts_ok, ir_on;
    logic        brk_act_r, tx_shin;
    assign ir_on  = mode_r.infrared_enable & ~mode_r.high_speed_clocking;
    assign cts_ok = mode_r.pin_select != 2'b10 || !cts_s;       // RULE5
    assign tx_load = run && tx_enable_r && tx_st_r == TX_IDLE
                     && (tx_cnt_r != '0 || send_break_r) && cts_ok;
    assign tx_done = tx_st_r == TX_SHIFT && tick && tx_sub_r == spb - 5'd1
                     && tx_bits_r == 4'h0;
    // a break shifts in one more zero: start plus twelve zeros, then stop
    assign tx_shin = !(brk_act_r && tx_bits_r == `BRK_BITS + 4'h1);
    // frame word: stop bits above data, parity as ninth bit
    function automatic logic [11:0] frame(input logic [8:0] d,
                                          input logic [1:0] f);
        logic [8:0] w;
        w = d;
        if (f == 2'b01)
            w[8] = ^d[7:0];                                     // RULE10
        else if (f == 2'b10)
            w[8] = ~^d[7:0];
        else if (f == 2'b00)
            w[8] = 1'b1;            // eight-bit frame: this cell is a stop bit
        return {2'b11, w, 1'b0};
    endfunction
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_st_r   <= TX_IDLE;
            tx_sh_r   <= 12'hFFF;
            tx_bits_r <= 4'h0;
            tx_sub_r  <= 5'h00;
            brk_act_r <= 1'b0;
        end
        else if (!tx_enable_r || !run)
        begin
            tx_st_r   <= TX_IDLE;                               // RULE15
            tx_sh_r   <= 12'hFFF;
            brk_act_r <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_st_r   <= TX_SHIFT;
            tx_sub_r  <= 5'h00;
            brk_act_r <= send_break_r;
            if (send_break_r)
            begin
                tx_sh_r   <= 12'h000;                           // RULE14
                tx_bits_r <= `BRK_BITS + 4'h1;
            end
            else
            begin
                tx_sh_r   <= frame(txq[tx_rd_r], mode_r.framing_select);
                tx_bits_r <= (mode_r.framing_select == 2'b00 ? 4'h9 : 4'hA)
                             + {3'b000, mode_r.stop_count_select}; // RULE11
            end
        end
        else if (tx_st_r == TX_SHIFT && tick)
        begin
            if (tx_sub_r == spb - 5'd1)
            begin
                tx_sub_r <= 5'h00;
                tx_sh_r  <= {tx_shin, tx_sh_r[11:1]};
                if (tx_bits_r == 4'h0)
                    tx_st_r <= TX_IDLE;
                else
                    tx_bits_r <= tx_bits_r - 4'h1;
            end
            else
                tx_sub_r <= tx_sub_r + 5'h01;
        end
    end
    assign tx_line = tx_sh_r[0];
    // infrared: a pulse in the first quarter of each zero bit
    assign ir_tx = ~tx_line && tx_sub_r < {2'b00, spb[4:2]};    // RULE3
    // pin drive and polarity
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            serial_out_pin <= 1'b1;
        else if (ir_on)
            serial_out_pin <= ir_tx ^ tx_pol_r;                 // RULE13
        else
            serial_out_pin <= tx_line ^ tx_pol_r;
    end
    assign serial_out_oe = mode_r.port_enable & tx_enable_r;    // RULE1
    assign request_to_send_oe = mode_r.port_enable
                                && (mode_r.pin_select == 2'b01
                                || mode_r.pin_select == 2'b10);
    assign baud_clock_oe = mode_r.port_enable
                           && mode_r.pin_select == 2'b11;
    // rts: simplex drives active while sending, flow asserts when room
    assign request_to_send_pin = mode_r.rts_pin_mode
                                 ? (tx_st_r == TX_IDLE)          // RULE4
                                 : (rx_cnt_r == DEPTH[PW:0]);
    // tx queue
    logic tx_pop;
    assign tx_pop = tx_load && !send_break_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_cnt_r <= '0;
            tx_rd_r  <= '0;
            tx_wr_r  <= '0;
        end
        else if (!tx_enable_r)
        begin
            tx_cnt_r <= '0;                                     // RULE15
            tx_rd_r  <= '0;
            tx_wr_r  <= '0;
        end
        else
        begin
            if (txq_push)
            begin
                txq[tx_wr_r] <= hwdata[8:0];                    // RULE23
                tx_wr_r      <= tx_wr_r + 1'b1;
            end
            if (tx_pop)
                tx_rd_r <= tx_rd_r + 1'b1;
            tx_cnt_r <= tx_cnt_r + {{PW{1'b0}}, txq_push}
                        - {{PW{1'b0}}, tx_pop};
        end
    end
    // transmit interrupt pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tx_irq <= 1'b0;
        else
            unique case (tx_irq_mode_r)                         // RULE12
                2'b00:   tx_irq <= tx_pop;
                2'b10:   tx_irq <= tx_pop && tx_cnt_r == 1 && !txq_push;
                2'b01:   tx_irq <= tx_done && tx_cnt_r == '0;
                default: tx_irq <= 1'b0;
            endcase
    end
    // =========================================================
    // receiver
    rx_state_t   rx_st_r;
    logic        rx_in, rx_prev_r, rx_store, rx_keep;
    logic [11:0] rx_shift_register;
    logic [3:0]  rx_bits_r, rx_len;
    logic [4:0]  rx_sub_r;
    logic [8:0]  rx_d;
    logic        rx_parity_error, rx_framing_error;
    assign rx_in = mode_r.loopback_select ? tx_line              // RULE24
                   : rx_pin_s ^ mode_r.rx_polarity_invert;      // RULE8
    assign rx_len = (mode_r.framing_select == 2'b00) ? 4'h9 : 4'hA;
    // the stop bit lands in the top cell, the data just below it
    assign rx_d   = (mode_r.framing_select == 2'b00)
                    ? {1'b0, rx_shift_register[10:3]}
                    : rx_shift_register[10:2];
    assign rx_parity_error = (mode_r.framing_select == 2'b01 && ^rx_d)
                     || (mode_r.framing_select == 2'b10 && ~^rx_d);
    assign rx_framing_error = ~rx_shift_register[11];
    assign rx_store = rx_st_r == RX_SHIFT && tick
                      && rx_sub_r == spb - 5'd1 && rx_bits_r == 4'h0;
    assign rx_keep = !(addr_det_r && mode_r.framing_select == 2'b11
                       && !rx_d[8])                             // RULE18
                     && !(mode_r.auto_rate_enable
                          && rx_d[7:0] == `SYNC_BYTE);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_st_r           <= RX_IDLE;
            rx_shift_register <= 12'h000;
            rx_bits_r         <= 4'h0;
            rx_sub_r          <= 5'h00;
            rx_prev_r         <= 1'b1;
        end
        else if (!run || overrun_error_clr)
        begin
            rx_st_r           <= RX_IDLE;                       // RULE21
            rx_shift_register <= 12'h000;
        end
        else
        begin
            rx_prev_r <= rx_in;
            if (rx_st_r == RX_IDLE && rx_prev_r && !rx_in)
            begin
                rx_st_r   <= RX_SHIFT;                          // RULE19
                rx_sub_r  <= 5'h00;
                rx_bits_r <= rx_len;
            end
            else if (rx_st_r == RX_SHIFT && tick)
            begin
                if (rx_sub_r == {1'b0, spb[4:1]})
                    rx_shift_register <= {rx_in, rx_shift_register[11:1]};
                if (rx_sub_r == spb - 5'd1)
                begin
                    rx_sub_r <= 5'h00;
                    if (rx_bits_r == 4'h0)
                        rx_st_r <= RX_IDLE;
                    else
                        rx_bits_r <= rx_bits_r - 4'h1;
                end
                else
                    rx_sub_r <= rx_sub_r + 5'h01;
            end
        end
    end
    // rx queue with per-entry error flags
    logic rx_push, rx_full;
    assign rx_full = rx_cnt_r == DEPTH[PW:0];
    assign rx_push = rx_store && rx_keep && !rx_full && !overrun_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_cnt_r <= '0;
            rx_rd_r  <= '0;
            rx_wr_r  <= '0;
        end
        else if (overrun_error_clr)
        begin
            rx_cnt_r <= '0;                                     // RULE21
            rx_rd_r  <= '0;
            rx_wr_r  <= '0;
        end
        else
        begin
            if (rx_push)
            begin
                rxq[rx_wr_r] <= {rx_parity_error, rx_framing_error, rx_d};       // RULE20
                rx_wr_r      <= rx_wr_r + 1'b1;
            end
            if (rxq_pop)
                rx_rd_r <= rx_rd_r + 1'b1;
            rx_cnt_r <= rx_cnt_r + {{PW{1'b0}}, rx_push}
                        - {{PW{1'b0}}, rxq_pop};
        end
    end
    // overrun: hardware set wins over software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            overrun_r <= 1'b0;
        else if (rx_store && rx_keep && rx_full)
            overrun_r <= 1'b1;                                  // RULE21
        else if (overrun_error_clr)
            overrun_r <= 1'b0;
    end
    // receive interrupt pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rx_irq <= 1'b0;
        else if (rx_irq_mode_r == 2'b11)
            rx_irq <= rx_push && rx_cnt_r == 3;                 // RULE17
        else if (rx_irq_mode_r == 2'b10)
            rx_irq <= rx_push && rx_cnt_r == 2;
        else
            rx_irq <= rx_push;
    end
    // =========================================================
    // control registers; software writes win over hardware clears
    logic wake_fall, wake_rise, sync_seen;
    assign wake_fall = mode_r.wake_enable && rx_prev_r && !rx_in;
    assign wake_rise = mode_r.wake_enable && !rx_prev_r && rx_in;
    assign sync_seen = rx_store && rx_d[7:0] == `SYNC_BYTE;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r        <= '0;
            tx_irq_mode_r <= 2'b00;
            rx_irq_mode_r <= 2'b00;
            tx_pol_r      <= 1'b0;
            send_break_r  <= 1'b0;
            tx_enable_r   <= 1'b0;
            addr_det_r    <= 1'b0;
            div_r         <= `DIV_RESET;
        end
        else
        begin
            if (do_wr && addr_r == `MODE_ADDR)
            begin
                mode_r          <= mode_t'(hwdata[15:0]);
                mode_r.unused14 <= 1'b0;
                mode_r.unused10 <= 1'b0;
            end
            else
            begin
                if (wake_rise)
                    mode_r.wake_enable <= 1'b0;                 // RULE6
                if (sync_seen && mode_r.auto_rate_enable)
                    mode_r.auto_rate_enable <= 1'b0;            // RULE7
            end
            if (do_wr && addr_r == `STAT_ADDR)
            begin
                tx_irq_mode_r <= {hwdata[15], hwdata[13]};
                tx_pol_r      <= hwdata[14];
                send_break_r  <= hwdata[11];
                tx_enable_r   <= hwdata[10];
                rx_irq_mode_r <= hwdata[7:6];
                addr_det_r    <= hwdata[5];
            end
            else if (tx_done && brk_act_r)
                send_break_r <= 1'b0;                           // RULE14
            if (do_wr && addr_r == `DIV_ADDR)
                div_r <= hwdata[15:0];
        end
    end
    assign wake_irq = wake_fall;                                // RULE6
    // =========================================================
    // read data
    logic [15:0] stat_v;
    logic [10:0] head;
    assign head   = rxq[rx_rd_r];
    assign stat_v = {tx_irq_mode_r[1], tx_pol_r, tx_irq_mode_r[0], 1'b0,
                     send_break_r, tx_enable_r,
                     tx_cnt_r == DEPTH[PW:0],                   // RULE16
                     tx_cnt_r == '0 && tx_st_r == TX_IDLE,
                     rx_irq_mode_r, addr_det_r,
                     rx_st_r == RX_IDLE,                        // RULE19
                     rx_cnt_r != '0 && head[10],                // RULE20
                     rx_cnt_r != '0 && head[9],
                     overrun_r, rx_cnt_r != '0};                // RULE22
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hrdata <= 32'h0000_0000;
        else if (a_ph && !hwrite)
            unique case (haddr)
                `MODE_ADDR: hrdata <= {16'h0000, mode_r};
                `STAT_ADDR: hrdata <= {16'h0000, stat_v};
                `DATA_ADDR: hrdata <= {23'h00_0000, head[8:0]};
                `DIV_ADDR:  hrdata <= {16'h0000, div_r};
                default:    hrdata <= 32'h0000_0000;
            endcase
    end
    // =========================================================
    // checks
    property p_shift_empty;
        @(posedge clk) disable iff (rst)
        tx_load |=> !stat_v[8];
    endproperty
    a_shift_empty: assert property (p_shift_empty)  // RULE16
        else $error("shift empty flag set during send");
    property p_avail;
        @(posedge clk) disable iff (rst)
        rx_push |=> stat_v[0];
    endproperty
    a_avail: assert property (p_avail)  // RULE22
        else $error("data available not raised");
    property p_overrun_error_flush;
        @(posedge clk) disable iff (rst)
        overrun_error_clr && !(rx_store && rx_full) |=> rx_cnt_r == '0;
    endproperty
    a_overrun_error_flush: assert property (p_overrun_error_flush)  // RULE21
        else $error("overrun clear did not flush");
    property p_tx_abort;
        @(posedge clk) disable iff (rst)
        !tx_enable_r |=> tx_cnt_r == '0 && tx_st_r == TX_IDLE;
    endproperty
    a_tx_abort: assert property (p_tx_abort)  // RULE15
        else $error("transmitter not aborted");
    property p_full;
        @(posedge clk) disable iff (rst)
        tx_cnt_r == DEPTH[PW:0] |-> stat_v[9];
    endproperty
    a_full: assert property (p_full)  // RULE16
        else $error("buffer full flag missing");
    property p_depth;
        @(posedge clk) disable iff (rst)
        tx_cnt_r <= DEPTH[PW:0] && rx_cnt_r <= DEPTH[PW:0];
    endproperty
    a_depth: assert property (p_depth)  // RULE23
        else $error("queue count beyond depth");
    property p_idle;
        @(posedge clk) disable iff (rst)
        rx_st_r == RX_SHIFT |-> !stat_v[4];
    endproperty
    a_idle: assert property (p_idle)  // RULE19
        else $error("idle flag while receiving");
    property p_txirq;
        @(posedge clk) disable iff (rst)
        tx_irq_mode_r == 2'b00 && tx_pop |=> tx_irq;
    endproperty
    a_txirq: assert property (p_txirq)  // RULE12
        else $error("tx interrupt missing");
endmodule // uart_ctl

// ===== verification/uart_far_end.sv
// Purpose: far-side serial device model for the port bench
// Assumes: line idles high through a pull-up when nobody drives it
// Notes:   echoes the port's own transmit line back to its receiver
`timescale 1ns/10ps
module uart_far_end (
    // port-side pins
    input  wire logic line_from_port,
    input  wire logic line_from_port_oe,
    output logic      line_to_port,
    output logic      cts_n
);
    // echo while driven; a released line falls to the pull-up level
    assign line_to_port = line_from_port_oe ? line_from_port : 1'b1;
    // always ready, so flow control never stalls the port
    assign cts_n = 1'b0;
endmodule // uart_far_end

// ===== verification/tb.sv
// Purpose: self-checking bench of the serial port control block
// Assumes: zero-wait slave, registered read data
// Notes:   echo through the far-side model gives a receive path
`timescale 1ns/10ps
`include "uart_ctl_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    err_total++; $display("MISMATCH %0t got %h", $time, (a)); end end
module tb;
    import uart_ctl_pkg::*;
    logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, device_idle = 0;
    logic [7:0]  haddr = '0;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0, hrdata, rd;
    logic        hreadyout, hresp, sin, cts_n, sout, sout_oe;
    logic        txi, rxi, tx_seen = 0, rx_seen = 0;
    int          err_total = 0, samples_checked = 0, cyc = 0;
    // register reset values and an unmapped place, address beside value
    logic [39:0] rows [3] = '{{`STAT_ADDR, 32'h0000_0110},
                              {`MODE_ADDR, 32'h0000_0000},
                              {8'h10,      32'h0000_0000}};
    uart_ctl uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .device_idle(device_idle), .serial_in_pin(sin),
        .clear_to_send_pin(cts_n), .serial_out_pin(sout),
        .serial_out_oe(sout_oe), .request_to_send_pin(),
        .request_to_send_oe(), .baud_clock_out(), .baud_clock_oe(),
        .tx_irq(txi), .rx_irq(rxi), .wake_irq());
    uart_far_end far (.line_from_port(sout), .line_from_port_oe(sout_oe),
        .line_to_port(sin), .cts_n(cts_n));
    // =========================================================
    // clock and hang guard
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (txi)
            tx_seen <= 1'b1;
        if (rxi)
            rx_seen <= 1'b1;
        if (cyc > 20000)
        begin
            err_total++;
            print_verdict();
        end
    end
    // one single-word transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic print_verdict();
        $display("errors %0d of %0d checks", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // =========================================================
    // main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            xfer(1'b0, rows[i][39:32], '0);
            `CHK(rd, rows[i][31:0])
        end
        `CHK(hresp, 1'b0)
        // enable port and transmitter, pins pass to the port
        xfer(1'b1, `MODE_ADDR, 32'h0000_8000);
        xfer(1'b1, `STAT_ADDR, 32'h0000_0400);
        @(posedge clk);
        `CHK(sout_oe, 1'b1)
        xfer(1'b1, `DATA_ADDR, 32'h0000_00A5);
        xfer(1'b0, `STAT_ADDR, '0);
        `CHK(rd[8], 1'b0)
        // wait for the echoed character under a bound
        for (int k = 0; k < 600 && rd[0] !== 1'b1; k++)
            xfer(1'b0, `STAT_ADDR, '0);
        `CHK(rd[8], 1'b1)
        `CHK(rd[4], 1'b1)
        `CHK(rd[0], 1'b1)
        xfer(1'b0, `DATA_ADDR, '0);
        `CHK(rd[7:0], 8'hA5)
        xfer(1'b0, `STAT_ADDR, '0);
        `CHK(rd[0], 1'b0)
        `CHK(tx_seen, 1'b1)
        `CHK(rx_seen, 1'b1)
        // five echoed characters overflow the four-deep receive queue
        repeat (5) xfer(1'b1, `DATA_ADDR, 32'h0000_003C);
        for (int k = 0; k < 900 && rd[1] !== 1'b1; k++)
            xfer(1'b0, `STAT_ADDR, '0);
        `CHK(rd[1], 1'b1)
        `CHK(rd[0], 1'b1)
        // software clear of overrun flushes the receiver
        xfer(1'b1, `STAT_ADDR, 32'h0000_0400);
        xfer(1'b0, `STAT_ADDR, '0);
        `CHK(rd[1:0], 2'b00)
        // clearing the transmitter hands the pin back
        xfer(1'b1, `STAT_ADDR, 32'h0000_0000);
        @(posedge clk);
        `CHK(sout_oe, 1'b0)
        `CHK(sout, 1'b1)
        print_verdict();
    end
endmodule // tb
